// [pkg/lsc_pkg.sv]
// register map, field layout and reset values of the low-speed lane config
package lsc_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int LSC_LANES     = 8;
    localparam int LSC_LANE_REGS = 7;
    localparam int LSC_ADDR_W    = 5;
    localparam int LSC_DATA_W    = 16;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] LSC_ADDR_HS_CTRL_FOUR   = 5'h05;
    localparam logic [4:0] LSC_ADDR_PLL_LANE_CTRL  = 5'h06;
    localparam logic [4:0] LSC_ADDR_CTRL_TWO       = 5'h07;
    localparam logic [4:0] LSC_ADDR_CTRL_THREE     = 5'h08;
    localparam logic [4:0] LSC_ADDR_OVERLAY        = 5'h09;
    localparam logic [4:0] LSC_ADDR_ALIGN_CODE     = 5'h0A;
    localparam logic [4:0] LSC_ADDR_LOSS_TXFIFO    = 5'h0B;
    localparam logic [4:0] LSC_ADDR_LANE_SOURCE    = 5'h0C;
    localparam logic [4:0] LSC_ADDR_CHANNEL_ONE    = 5'h0D;
    localparam logic [4:0] LSC_ADDR_ERR_COUNTER    = 5'h10;
    localparam logic [4:0] LSC_ADDR_LOSS_COUNT     = 5'h11;
    localparam logic [4:0] LSC_ADDR_STATUS_ONE     = 5'h12;

    // lane register slot order, index 7 means "not a lane register"
    localparam logic [2:0] LSC_SLOT_CTRL_TWO    = 3'h0;
    localparam logic [2:0] LSC_SLOT_CTRL_THREE  = 3'h1;
    localparam logic [2:0] LSC_SLOT_OVERLAY     = 3'h2;
    localparam logic [2:0] LSC_SLOT_ALIGN_CODE  = 3'h3;
    localparam logic [2:0] LSC_SLOT_LOSS_TXFIFO = 3'h4;
    localparam logic [2:0] LSC_SLOT_LANE_SOURCE = 3'h5;
    localparam logic [2:0] LSC_SLOT_CHANNEL_ONE = 3'h6;
    localparam logic [2:0] LSC_SLOT_NONE        = 3'h7;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int LSC_BCAST_BIT    = 15;
    localparam int LSC_LANE_SEL_HI  = 14;
    localparam int LSC_LANE_SEL_LO  = 12;
    localparam int LSC_LOOP_BW_HI   = 9;
    localparam int LSC_LOOP_BW_LO   = 8;
    localparam int LSC_PLL_ON_BIT   = 4;
    localparam int LSC_MULT_HI      = 3;
    localparam int LSC_MULT_LO      = 0;
    localparam int LSC_PRECUR_HI    = 7;
    localparam int LSC_PRECUR_LO    = 4;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] LSC_RST_PLL_LANE_CTRL = 16'h8115;
    localparam logic [15:0] LSC_RST_HS_CTRL_FOUR  = 16'h2000;
    localparam logic [15:0] LSC_RST_CTRL_TWO      = 16'hDD05;
    localparam logic [15:0] LSC_RST_CTRL_THREE    = 16'h000D;
    localparam logic [15:0] LSC_RST_LANE_OTHER    = 16'h0000;

    // multiplier and tap weight encodings
    localparam logic [7:0]  LSC_MULT_X2_NONE = 8'h00;
    localparam logic [3:0]  LSC_TAP_ZERO     = 4'h0;

endpackage

// [rtl/lsc_pll_decode.sv]
// decode of pll multiplier code and transmit pre-cursor tap weight
`timescale 1ns/1ps
module lsc_pll_decode (
    input  wire logic [3:0] mult_code_in,    // pll multiplier field
    input  wire logic [3:0] precur_code_in,  // pre-cursor weight field
    output logic      [7:0] mult_x2_out,     // factor times two, 0 = reserved
    output logic            mult_valid_out,  // code is not reserved
    output logic signed [3:0] precur_steps_out // weight in 2.5 percent steps
);
    import lsc_pkg::*;

    // ------------------------------------------------------------------
    // multiplier: doubled so that 12.5x stays an integer
    // ------------------------------------------------------------------
    always_comb begin
        mult_valid_out = 1'b1;
        unique case (mult_code_in)
            4'h0: mult_x2_out = 8'h08;
            4'h1: mult_x2_out = 8'h0A;
            4'h2: mult_x2_out = 8'h0C;
            4'h4: mult_x2_out = 8'h10;
            4'h5: mult_x2_out = 8'h14;
            4'h6: mult_x2_out = 8'h18;
            4'h7: mult_x2_out = 8'h19;
            4'h8: mult_x2_out = 8'h1E;
            4'h9: mult_x2_out = 8'h28;
            4'hA: mult_x2_out = 8'h32;
            4'hD: mult_x2_out = 8'h64;
            4'hE: mult_x2_out = 8'h82;
            default: begin
                // reserved codes: pll behaviour left undefined
                mult_x2_out    = LSC_MULT_X2_NONE;
                mult_valid_out = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // tap weight: sign-magnitude, both zero codes give zero
    // ------------------------------------------------------------------
    always_comb begin
        if (precur_code_in[3]) begin
            precur_steps_out = -$signed({1'b0, precur_code_in[2:0]});
        end else begin
            precur_steps_out = $signed({1'b0, precur_code_in[2:0]});
        end
    end

endmodule

// [rtl/lsc_top.sv]
// low-speed serdes lane configuration registers and pll control
`timescale 1ns/1ps
module lsc_top #(
    parameter int LANES = lsc_pkg::LSC_LANES  // number of low-speed lanes
) (
    input  wire logic                      clk_sys_in,        // register clock
    input  wire logic                      reset_n_in,        // async reset
    input  wire logic [lsc_pkg::LSC_ADDR_W-1:0] reg_addr_in,  // register addr
    input  wire logic                      reg_wr_in,         // write strobe
    input  wire logic [lsc_pkg::LSC_DATA_W-1:0] reg_wdata_in, // write data
    output logic      [lsc_pkg::LSC_DATA_W-1:0] reg_rdata_out,// read data
    input  wire logic                      lane_powerdown_n_in, // low: off
    input  wire logic                      global_powerdown_in, // bit 1.15
    input  wire logic [LANES*16-1:0]       lane_error_counter_in,  // per lane
    input  wire logic [LANES*16-1:0]       rx_signal_loss_count_in, // per lane
    input  wire logic [LANES*16-1:0]       lowspeed_status_one_in, // per lane
    output logic [LANES*16-1:0]            lowspeed_ctrl_two_out,   // per lane
    output logic [LANES*16-1:0]            lowspeed_ctrl_three_out, // per lane
    output logic [LANES*16-1:0]            test_pattern_overlay_ctrl_out, // lane
    output logic [LANES*16-1:0]            alignment_code_ctrl_out, // per lane
    output logic [LANES*16-1:0]            signal_loss_txfifo_ctrl_out, // lane
    output logic [LANES*16-1:0]            lane_source_ctrl_out,    // per lane
    output logic [LANES*16-1:0]            channel_ctrl_one_out,    // per lane
    output logic                           pll_on_out,        // pll running
    output logic [1:0]                     pll_loop_bw_out,   // loop bandwidth
    output logic [7:0]                     pll_mult_x2_out,   // factor x2
    output logic                           pll_mult_valid_out, // code legal
    output logic signed [3:0]              tx_precursor_weight_out // steps
);
    import lsc_pkg::*;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [15:0] pll_lane_ctrl;
    logic [15:0] hs_ctrl_four;
    logic [15:0] lane_reg [LANES][LSC_LANE_REGS];

    logic        broadcast_lane_write;
    logic [2:0]  lane_select;
    logic [2:0]  wr_slot;
    logic [2:0]  rd_slot;
    logic        lane_wr_hit;
    logic [LANES-1:0] lane_wr_en;
    logic [15:0] next_rdata;
    logic [7:0]  mult_x2;
    logic        mult_valid;
    logic signed [3:0] precur_steps;

    assign broadcast_lane_write = pll_lane_ctrl[LSC_BCAST_BIT];
    assign lane_select = pll_lane_ctrl[LSC_LANE_SEL_HI:LSC_LANE_SEL_LO];

    // ------------------------------------------------------------------
    // address to lane register slot
    // ------------------------------------------------------------------
    function automatic logic [2:0] slot_of(input logic [4:0] addr);
        logic [2:0] slot;
        slot = LSC_SLOT_NONE;
        unique case (addr)
            LSC_ADDR_CTRL_TWO:    slot = LSC_SLOT_CTRL_TWO;
            LSC_ADDR_CTRL_THREE:  slot = LSC_SLOT_CTRL_THREE;
            LSC_ADDR_OVERLAY:     slot = LSC_SLOT_OVERLAY;
            LSC_ADDR_ALIGN_CODE:  slot = LSC_SLOT_ALIGN_CODE;
            LSC_ADDR_LOSS_TXFIFO: slot = LSC_SLOT_LOSS_TXFIFO;
            LSC_ADDR_LANE_SOURCE: slot = LSC_SLOT_LANE_SOURCE;
            LSC_ADDR_CHANNEL_ONE: slot = LSC_SLOT_CHANNEL_ONE;
            default:              slot = LSC_SLOT_NONE;
        endcase
        return slot;
    endfunction

    function automatic logic [15:0] lane_reset(input int slot);
        logic [15:0] val;
        val = LSC_RST_LANE_OTHER;
        if (slot == int'(LSC_SLOT_CTRL_TWO)) begin
            val = LSC_RST_CTRL_TWO;
        end else if (slot == int'(LSC_SLOT_CTRL_THREE)) begin
            val = LSC_RST_CTRL_THREE;
        end
        return val;
    endfunction

    assign wr_slot     = slot_of(reg_addr_in);
    assign rd_slot     = wr_slot;
    assign lane_wr_hit = reg_wr_in && (wr_slot != LSC_SLOT_NONE);

    // ------------------------------------------------------------------
    // global registers
    // ------------------------------------------------------------------
    // every bit is plain read/write, reserved bits included
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pll_lane_ctrl <= LSC_RST_PLL_LANE_CTRL;
        end else if (reg_wr_in && reg_addr_in == LSC_ADDR_PLL_LANE_CTRL) begin
            pll_lane_ctrl <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hs_ctrl_four <= LSC_RST_HS_CTRL_FOUR;
        end else if (reg_wr_in && reg_addr_in == LSC_ADDR_HS_CTRL_FOUR) begin
            hs_ctrl_four <= reg_wdata_in;
        end
    end

    // ------------------------------------------------------------------
    // per-lane registers
    // ------------------------------------------------------------------
    // the write uses the lane select held before this write, so a write to
    // the control register takes effect from the next lane access on
    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_lane
            assign lane_wr_en[gl] = lane_wr_hit &&
                (broadcast_lane_write ||
                 lane_select == 3'(gl));

            always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    for (int r = 0; r < LSC_LANE_REGS; r++) begin
                        lane_reg[gl][r] <= lane_reset(r);
                    end
                end else if (lane_wr_en[gl]) begin
                    lane_reg[gl][wr_slot] <= reg_wdata_in;
                end
            end

            assign lowspeed_ctrl_two_out[gl*16 +: 16] =
                lane_reg[gl][LSC_SLOT_CTRL_TWO];
            assign lowspeed_ctrl_three_out[gl*16 +: 16] =
                lane_reg[gl][LSC_SLOT_CTRL_THREE];
            assign test_pattern_overlay_ctrl_out[gl*16 +: 16] =
                lane_reg[gl][LSC_SLOT_OVERLAY];
            assign alignment_code_ctrl_out[gl*16 +: 16] =
                lane_reg[gl][LSC_SLOT_ALIGN_CODE];
            assign signal_loss_txfifo_ctrl_out[gl*16 +: 16] =
                lane_reg[gl][LSC_SLOT_LOSS_TXFIFO];
            assign lane_source_ctrl_out[gl*16 +: 16] =
                lane_reg[gl][LSC_SLOT_LANE_SOURCE];
            assign channel_ctrl_one_out[gl*16 +: 16] =
                lane_reg[gl][LSC_SLOT_CHANNEL_ONE];
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // lane register reads show the selected lane even in broadcast mode
    always_comb begin
        next_rdata = 16'h0000;
        if (rd_slot != LSC_SLOT_NONE) begin
            next_rdata = lane_reg[lane_select][rd_slot];
        end else begin
            unique case (reg_addr_in)
                LSC_ADDR_PLL_LANE_CTRL: next_rdata = pll_lane_ctrl;
                LSC_ADDR_HS_CTRL_FOUR:  next_rdata = hs_ctrl_four;
                LSC_ADDR_ERR_COUNTER:
                    next_rdata = lane_error_counter_in[lane_select*16 +: 16];
                LSC_ADDR_LOSS_COUNT:
                    next_rdata = rx_signal_loss_count_in[lane_select*16 +: 16];
                LSC_ADDR_STATUS_ONE:
                    next_rdata = lowspeed_status_one_in[lane_select*16 +: 16];
                default:                next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 16'h0000;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // pll control
    // ------------------------------------------------------------------
    lsc_pll_decode u_decode (
        .mult_code_in     (pll_lane_ctrl[LSC_MULT_HI:LSC_MULT_LO]),
        .precur_code_in   (hs_ctrl_four[LSC_PRECUR_HI:LSC_PRECUR_LO]),
        .mult_x2_out      (mult_x2),
        .mult_valid_out   (mult_valid),
        .precur_steps_out (precur_steps)
    );

    // registered so the analog controls never see a decode glitch
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pll_on_out <= 1'b0;
        end else begin
            pll_on_out <= pll_lane_ctrl[LSC_PLL_ON_BIT] &&
                          lane_powerdown_n_in &&
                          !global_powerdown_in;
        end
    end

    // bandwidth passed through as written; no check of reserved codes
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pll_loop_bw_out    <= 2'h0;
            pll_mult_x2_out    <= LSC_MULT_X2_NONE;
            pll_mult_valid_out <= 1'b0;
        end else begin
            pll_loop_bw_out    <= pll_lane_ctrl[LSC_LOOP_BW_HI:LSC_LOOP_BW_LO];
            pll_mult_x2_out    <= mult_x2;
            pll_mult_valid_out <= mult_valid;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_precursor_weight_out <= LSC_TAP_ZERO;
        end else begin
            tx_precursor_weight_out <= precur_steps;
        end
    end

endmodule

// [tb/lsc_checker.sv]
// concurrent checks on the ports of the lane config register block
`timescale 1ns/1ps
module lsc_checker #(
    parameter int LANES = 8  // number of lanes
) (
    input wire logic                   clk_sys_in,      // register clock
    input wire logic                   reset_n_in,      // async reset
    input wire logic [lsc_pkg::LSC_ADDR_W-1:0] reg_addr_in, // address
    input wire logic                   reg_wr_in,       // write strobe
    input wire logic [lsc_pkg::LSC_DATA_W-1:0] reg_wdata_in, // write data
    input wire logic [lsc_pkg::LSC_DATA_W-1:0] reg_rdata_out, // read data
    input wire logic                   lane_powerdown_n_in, // low: off
    input wire logic                   global_powerdown_in, // high: off
    input wire logic [LANES*16-1:0]    lane_error_counter_in,   // per lane
    input wire logic [LANES*16-1:0]    lowspeed_ctrl_two_out,   // per lane
    input wire logic [LANES*16-1:0]    lowspeed_ctrl_three_out, // per lane
    input wire logic                   pll_on_out,      // pll running
    input wire logic [1:0]             pll_loop_bw_out, // loop bandwidth
    input wire logic [7:0]             pll_mult_x2_out, // factor x2
    input wire logic                   pll_mult_valid_out, // code legal
    input wire logic signed [3:0]      tx_precursor_weight_out // steps
);
    import lsc_pkg::*;
    // ------------------------------------------------------------------
    // shadow registers
    // ------------------------------------------------------------------
    logic [15:0] ctl;
    logic [15:0] hs;
    logic        run_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctl   <= LSC_RST_PLL_LANE_CTRL;
            hs    <= LSC_RST_HS_CTRL_FOUR;
            run_q <= 1'b0;
        end else begin
            run_q <= 1'b1;
            if (reg_wr_in && reg_addr_in == LSC_ADDR_PLL_LANE_CTRL)
                ctl <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == LSC_ADDR_HS_CTRL_FOUR)
                hs <= reg_wdata_in;
        end
    end
    wire logic [2:0]          sel  = ctl[14:12];
    wire logic                en   = ctl[LSC_PLL_ON_BIT];
    wire logic [1:0]          bw   = ctl[9:8];
    wire logic [3:0]          mc   = ctl[3:0];
    wire logic [3:0]          tap  = hs[7:4];
    wire logic [15:0]         esel = lane_error_counter_in[16*sel +: 16];
    wire logic [LANES*16-1:0] mask = {{(LANES-1)*16{1'b0}}, 16'hFFFF}
                                     << (16*sel);
    function automatic logic [7:0] x2_of(input logic [3:0] c);
        case (c)
            4'h0: return 8'h08;    4'h1: return 8'h0A;
            4'h2: return 8'h0C;    4'h4: return 8'h10;
            4'h5: return 8'h14;    4'h6: return 8'h18;
            4'h7: return 8'h19;    4'h8: return 8'h1E;
            4'h9: return 8'h28;    4'hA: return 8'h32;
            4'hD: return 8'h64;    4'hE: return 8'h82;
            default: return 8'h00;
        endcase
    endfunction
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_bcast;
        reg_wr_in && reg_addr_in == LSC_ADDR_CTRL_TWO && ctl[15];
    endsequence
    sequence s_lane_wr;
        reg_wr_in && reg_addr_in == LSC_ADDR_CTRL_THREE && !ctl[15];
    endsequence
    bcast_write_a: assert property (s_bcast |=>
        lowspeed_ctrl_two_out == {LANES{$past(reg_wdata_in)}})
        else $error("broadcast write missed a lane");
    lane_only_a: assert property (s_lane_wr |=>
        ((lowspeed_ctrl_three_out ^ $past(lowspeed_ctrl_three_out))
         & ~$past(mask)) == '0
        && lowspeed_ctrl_three_out[16*$past(sel) +: 16] == $past(reg_wdata_in))
        else $error("lane write reached the wrong lane");
    status_read_a: assert property (
        reg_addr_in == LSC_ADDR_ERR_COUNTER |=> reg_rdata_out == $past(esel))
        else $error("error counter of wrong lane read");
    ctl_readback_a: assert property (
        reg_addr_in == LSC_ADDR_PLL_LANE_CTRL |=> reg_rdata_out == $past(ctl))
        else $error("control register readback differs");
    pll_off_a: assert property (
        !lane_powerdown_n_in || global_powerdown_in |=> !pll_on_out)
        else $error("pll not forced off");
    pll_follow_a: assert property (run_q |-> pll_on_out ==
        ($past(en) && $past(lane_powerdown_n_in) && !$past(global_powerdown_in)))
        else $error("pll enable not followed");
    mult_map_a: assert property (run_q |->
        pll_mult_x2_out == x2_of($past(mc))
        && pll_mult_valid_out == (x2_of($past(mc)) != 8'h00))
        else $error("multiplier decode wrong");
    loop_bw_a: assert property (
        run_q |-> pll_loop_bw_out == $past(bw))
        else $error("loop bandwidth not passed on");
    tap_weight_a: assert property (run_q |->
        tx_precursor_weight_out == ($past(tap) > 4'h8 ?
        -$signed({1'b0, $past(tap) & 4'h7}) : $signed({1'b0, $past(tap) & 4'h7})))
        else $error("pre-cursor weight decode wrong");
endmodule
bind lsc_top lsc_checker #(.LANES(LANES)) u_lsc_checker (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .lane_powerdown_n_in(lane_powerdown_n_in),
    .global_powerdown_in(global_powerdown_in),
    .lane_error_counter_in(lane_error_counter_in),
    .lowspeed_ctrl_two_out(lowspeed_ctrl_two_out),
    .lowspeed_ctrl_three_out(lowspeed_ctrl_three_out),
    .pll_on_out(pll_on_out), .pll_loop_bw_out(pll_loop_bw_out),
    .pll_mult_x2_out(pll_mult_x2_out), .pll_mult_valid_out(pll_mult_valid_out),
    .tx_precursor_weight_out(tx_precursor_weight_out));

// [tb/lsc_top_tb.sv]
// self-checking bench for the lane config register block
`timescale 1ns/1ps
module lsc_top_tb;
    import lsc_pkg::*;
    localparam int W = LSC_LANES*16;
    typedef struct packed {logic [4:0] a; logic [15:0] rst, wd, ex;} lsc_row_s;
    logic        clk_sys_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0;
    logic [4:0]  reg_addr_in = 5'h00;
    logic [15:0] reg_wdata_in = 16'h0000, rd, v;
    logic        lane_powerdown_n_in = 1'b1, global_powerdown_in = 1'b0;
    logic [W-1:0] ec, lc, st, ev, lo [7];
    logic        pon, pvalid;
    logic [1:0]  pbw;
    logic [7:0]  px2;
    logic signed [3:0] pre, ps;
    int          err_total = 0, checks = 0, cycles = 0;
    logic [7:0]  mx [16] = '{8'h08, 8'h0A, 8'h0C, 8'h00, 8'h10, 8'h14,
        8'h18, 8'h19, 8'h1E, 8'h28, 8'h32, 8'h00, 8'h00, 8'h64, 8'h82, 8'h00};
    logic [4:0]  sa [3] = '{LSC_ADDR_ERR_COUNTER, LSC_ADDR_LOSS_COUNT,
                            LSC_ADDR_STATUS_ONE};
    logic [11:0] sb [3] = '{12'hE00, 12'hD00, 12'hB00};
    lsc_row_s rows [10] = '{'{5'h05, 16'h2000, 16'hA5F0, 16'hA5F0},
        '{5'h06, 16'h8115, 16'h8CE5, 16'h8CE5},
        '{5'h07, 16'hDD05, 16'h1234, 16'h1234},
        '{5'h08, 16'h000D, 16'h5678, 16'h5678},
        '{5'h09, 16'h0000, 16'h9ABC, 16'h9ABC},
        '{5'h0A, 16'h0000, 16'hDEF0, 16'hDEF0},
        '{5'h0B, 16'h0000, 16'h0F0F, 16'h0F0F},
        '{5'h0C, 16'h0000, 16'hF00F, 16'hF00F},
        '{5'h0D, 16'h0000, 16'h3C3C, 16'h3C3C},
        '{5'h1F, 16'h0000, 16'hFFFF, 16'h0000}};
    lsc_top u_lsc_top (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rd),
        .lane_powerdown_n_in(lane_powerdown_n_in),
        .global_powerdown_in(global_powerdown_in),
        .lane_error_counter_in(ec), .rx_signal_loss_count_in(lc),
        .lowspeed_status_one_in(st), .lowspeed_ctrl_two_out(lo[0]),
        .lowspeed_ctrl_three_out(lo[1]), .test_pattern_overlay_ctrl_out(lo[2]),
        .alignment_code_ctrl_out(lo[3]), .signal_loss_txfifo_ctrl_out(lo[4]),
        .lane_source_ctrl_out(lo[5]), .channel_ctrl_one_out(lo[6]),
        .pll_on_out(pon), .pll_loop_bw_out(pbw), .pll_mult_x2_out(px2),
        .pll_mult_valid_out(pvalid), .tx_precursor_weight_out(pre));
    always #12.5 clk_sys_in = ~clk_sys_in;
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic chk_lanes(input string n, input logic [W-1:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        tick();
        d = rd;
    endtask
    task automatic pins(input logic pd_n, glb, exp_on);
        @(posedge clk_sys_in);
        lane_powerdown_n_in <= pd_n;
        global_powerdown_in <= glb;
        tick();
        tick();
        chk_word("pll on", {15'h0, exp_on}, {15'h0, pon});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, the whole sequence needs under 2000 cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            close_out();
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int n = 0; n < LSC_LANES; n++) begin
            ec[16*n +: 16] <= {12'hE00, n[3:0]};
            lc[16*n +: 16] <= {12'hD00, n[3:0]};
            st[16*n +: 16] <= {12'hB00, n[3:0]};
        end
        repeat (10) @(posedge clk_sys_in);
        chk_word("data in reset", 16'h0000, rd);
        reset_n_in <= 1'b1;
        foreach (rows[i]) begin
            rd_reg(rows[i].a, v);
            chk_word("reset value", rows[i].rst, v);
            wr_reg(rows[i].a, rows[i].wd);
            rd_reg(rows[i].a, v);
            chk_word("readback", rows[i].ex, v);
            if (rows[i].a inside {[5'h07:5'h0D]})
                chk_lanes("lane copies", {LSC_LANES{rows[i].wd}},
                          lo[rows[i].a - 5'h07]);
        end
        $display("test register rows done");
        ev = {LSC_LANES{16'h5678}};
        for (int k = 0; k < 8; k++) begin
            ev[16*k +: 16] = {13'h1400, k[2:0]};
            wr_reg(LSC_ADDR_PLL_LANE_CTRL, {1'b0, k[2:0], 12'h115});
            wr_reg(LSC_ADDR_CTRL_THREE, {13'h1400, k[2:0]});
            tick();
            chk_lanes("selected lane", ev, lo[1]);
            rd_reg(LSC_ADDR_CTRL_THREE, v);
            chk_word("lane copy", {13'h1400, k[2:0]}, v);
            for (int j = 0; j < 3; j++) begin
                rd_reg(sa[j], v);
                chk_word("lane status", {sb[j], 1'b0, k[2:0]}, v);
            end
        end
        $display("test lane select done");
        wr_reg(LSC_ADDR_PLL_LANE_CTRL, 16'hD215);
        rd_reg(LSC_ADDR_ERR_COUNTER, v);
        chk_word("status with broadcast", 16'hE005, v);
        chk_word("loop bandwidth", 16'h0002, {14'h0, pbw});
        pins(1'b1, 1'b0, 1'b1);
        pins(1'b0, 1'b0, 1'b0);
        pins(1'b1, 1'b1, 1'b0);
        pins(1'b1, 1'b0, 1'b1);
        wr_reg(LSC_ADDR_PLL_LANE_CTRL, 16'hD205);
        pins(1'b1, 1'b0, 1'b0);
        $display("test pll enable done");
        for (int c = 0; c < 16; c++) begin
            wr_reg(LSC_ADDR_PLL_LANE_CTRL, {12'h811, c[3:0]});
            tick();
            chk_word("multiplier", {7'h0, mx[c] != 8'h00, mx[c]},
                     {7'h0, pvalid, px2});
            wr_reg(LSC_ADDR_HS_CTRL_FOUR, {8'h20, c[3:0], 4'h0});
            tick();
            ps = c[3] ? -$signed({1'b0, c[2:0]}) : $signed({1'b0, c[2:0]});
            chk_word("tap weight", {12'h0, ps}, {12'h0, pre});
        end
        $display("test decode tables done");
        @(posedge clk_sys_in);
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        rd_reg(LSC_ADDR_PLL_LANE_CTRL, v);
        chk_word("control after reset", 16'h8115, v);
        chk_lanes("lanes after reset", {LSC_LANES{16'hDD05}}, lo[0]);
        $display("test second reset done");
        close_out();
    end
endmodule
